// >>> timer_output_compare_unit_bench.sv
// self-checking bench for the timer output compare unit
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
    miscompares++; $display("MISMATCH t=%0t got %h exp %h", $time, got, \
    exp); end end
module timer_output_compare_unit_bench;
    import toc_pkg::*;
    logic        i_clk_sys = 1'b0;
    logic        i_arst_n  = 1'b0;
    logic        i_tick    = 1'b0;
    logic [3:0]  i_addr    = 4'h0;
    logic [15:0] i_wdata   = 16'h0000;
    logic        i_wr      = 1'b0;
    logic        i_rd      = 1'b0;
    logic [1:0]  i_port_val = 2'h0;
    logic [1:0]  i_pin_dir = 2'h0;
    logic [2:0]  i_irq_ack = 3'h0;
    logic [15:0] o_rdata;
    logic [2:0]  o_irq;
    logic [1:0]  o_pin_out;
    logic [1:0]  o_pin_oe;
    int          miscompares = 0;
    int          comparisons = 0;
    int          cyc = 0;
    int          m_cnt = 0, m_flg = 0, m_cs = 0, m_blk = 0, m_pnd = 0;
    int          m_md = 0;
    int          m_cmp[2] = '{0, 0};
    int          m_lat[2] = '{0, 0};
    int          m_act[2] = '{0, 0};
    logic [31:0] seed = 32'hFD5D6E0F;
    logic [15:0] d;
    logic [1:0]  pexp;
    logic [1:0]  acts[4] = '{TOC_ACT_SET, TOC_ACT_CLR, TOC_ACT_TOG,
                             TOC_ACT_NONE};

    toc_unit uut (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
        .i_tick(i_tick), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .i_port_val(i_port_val), .i_pin_dir(i_pin_dir),
        .i_irq_ack(i_irq_ack), .o_rdata(o_rdata), .o_irq(o_irq),
        .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe));

    initial begin
        forever #10 i_clk_sys = ~i_clk_sys;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic int apply(input int a, input int l);
        case (a)
            1: return l ^ 1;
            2: return 0;
            3: return 1;
            default: return l;
        endcase
    endfunction

    task automatic close_out();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // hang guard, the whole run needs well under a thousand cycles
    always @(posedge i_clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            close_out();
        end
    end

    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe edge
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 v = o_rdata;
    endtask

    task automatic tick();
        @(posedge i_clk_sys);
        i_tick <= 1'b1;
        @(posedge i_clk_sys);
        i_tick <= 1'b0;
        // a match raises its flag one timer tick later
        m_flg |= m_pnd;
        m_pnd = 0;
        if (m_cs != 0) begin
            for (int c = 0; c < 2; c++)
                if (m_blk == 0 && m_cnt == m_cmp[c]) begin
                    m_pnd |= 1 << c;
                    m_lat[c] = apply(m_act[c], m_lat[c]);
                end
            m_cnt = (m_cnt + 1) % 256;
            if (m_cnt == 0 && m_md == 0) m_flg |= 4;
        end
        // block ends at the next tick even with the clock stopped
        m_blk = 0;
    endtask

    task automatic wcnt(input int v);
        wr(TOC_A_COUNT, 16'(v));
        m_cnt = v;
        m_blk = 1;
    endtask

    task automatic ack(input int b);
        @(posedge i_clk_sys);
        i_irq_ack <= 3'(1 << b);
        @(posedge i_clk_sys);
        i_irq_ack <= 3'h0;
        m_flg &= ~(1 << b);
    endtask

    task automatic setctl(input int md, input int cs, input int aa,
                          input int ab);
        m_cs = cs;
        m_md = md;
        m_act[0] = aa;
        m_act[1] = ab;
        wr(TOC_A_CTRL, 16'(md + cs * 8 + aa * 64 + ab * 256));
    endtask

    task automatic chk_all();
        rd(TOC_A_COUNT, d);
        `CHK(d, 16'(m_cnt))
        rd(TOC_A_FLAGS, d);
        `CHK(d, 16'(m_flg))
        rd(TOC_A_STAT, d);
        `CHK(d, 16'(m_lat[0] + 2 * m_lat[1]))
        for (int c = 0; c < 2; c++)
            pexp[c] = (m_act[c] != 0) ? 1'(m_lat[c]) : i_port_val[c];
        `CHK(o_pin_out, pexp)
        `CHK(o_pin_oe, i_pin_dir)
    endtask

    initial begin
        repeat (20) @(posedge i_clk_sys);
        `CHK(o_pin_out, 2'h0)
        `CHK(o_irq, 3'h0)
        i_arst_n <= 1'b1;
        seed = lfsr(seed);
        i_port_val <= seed[1:0];
        rd(TOC_A_STAT, d);
        `CHK(d[1:0], 2'h0)
        // clear the latches by a force while the pins are still inputs
        setctl(0, 0, 2, 2);
        wr(TOC_A_FORCE, 16'h0003);
        i_pin_dir <= 2'h3;
        setctl(0, 1, 1, 0);
        wr(TOC_A_IEN, 16'h0007);
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            wcnt(int'(seed[7:0]));
            m_cmp[1] = 128 + int'(seed[13:8]);
            wr(TOC_A_CMPB, 16'(m_cmp[1]));
            rd(TOC_A_CMPB, d);
            `CHK(d, 16'(m_cmp[1]))
            chk_all();
        end
        rd(4'hF, d);
        `CHK(d, 16'h0000)
        m_cmp[0] = 16;
        wr(TOC_A_CMPA, 16'h0010);
        wcnt(15);
        tick();
        chk_all();
        // the match tick leaves the flag clear, the next tick sets it
        tick();
        chk_all();
        tick();
        chk_all();
        `CHK(o_irq, 3'(m_flg))
        ack(0);
        chk_all();
        // count write onto the compare value must swallow the match
        wcnt(16);
        tick();
        chk_all();
        wcnt(15);
        repeat (3) tick();
        wr(TOC_A_FLAGS, 16'h0002);
        chk_all();
        wr(TOC_A_FLAGS, 16'h0001);
        m_flg &= ~1;
        chk_all();
        for (int i = 0; i < 4; i++) begin
            setctl(0, 1, int'(acts[i]), int'(acts[i]));
            wr(TOC_A_FORCE, 16'h0003);
            for (int c = 0; c < 2; c++) m_lat[c] = apply(m_act[c], m_lat[c]);
            chk_all();
        end
        setctl(0, 1, 3, 0);
        wr(TOC_A_FORCE, 16'h0001);
        m_lat[0] = 1;
        setctl(3, 1, 0, 0);
        chk_all();
        // buffered write must not reach the comparator mid-sequence
        wr(TOC_A_CMPA, 16'h0030);
        rd(TOC_A_CMPA, d);
        `CHK(d, 16'h0030)
        wcnt(46);
        repeat (3) tick();
        chk_all();
        setctl(0, 1, 0, 0);
        m_cmp[0] = 64;
        wr(TOC_A_CMPA, 16'h0040);
        wcnt(254);
        tick();
        tick();
        chk_all();
        `CHK(o_irq, 3'(m_flg))
        ack(2);
        chk_all();
        setctl(0, 0, 0, 0);
        tick();
        chk_all();
        wcnt(85);
        chk_all();
        close_out();
    end
endmodule
`default_nettype wire

// >>> toc_pkg.sv
// constants for the timer output compare unit
package toc_pkg;
    localparam int          TOC_W         = 8;
    localparam logic [7:0]  TOC_BOTTOM    = 8'h00;
    localparam logic [7:0]  TOC_MAX       = 8'hFF;
    localparam logic [7:0]  TOC_ONE       = 8'h01;
    localparam logic [2:0]  TOC_CS_STOP   = 3'h0;
    // waveform mode encodings
    localparam logic [2:0]  TOC_WM_NORMAL = 3'h0;
    localparam logic [2:0]  TOC_WM_PCPWM  = 3'h1;
    localparam logic [2:0]  TOC_WM_CLRM   = 3'h2;
    localparam logic [2:0]  TOC_WM_FPWM   = 3'h3;
    localparam logic [2:0]  TOC_WM_PCPWM_A = 3'h5;
    localparam logic [2:0]  TOC_WM_FPWM_A = 3'h7;
    // compare output action encodings
    localparam logic [1:0]  TOC_ACT_NONE  = 2'h0;
    localparam logic [1:0]  TOC_ACT_TOG   = 2'h1;
    localparam logic [1:0]  TOC_ACT_CLR   = 2'h2;
    localparam logic [1:0]  TOC_ACT_SET   = 2'h3;
    // register map, word addresses on the plain port
    localparam logic [3:0]  TOC_A_COUNT   = 4'h0;
    localparam logic [3:0]  TOC_A_CMPA    = 4'h1;
    localparam logic [3:0]  TOC_A_CMPB    = 4'h2;
    localparam logic [3:0]  TOC_A_CTRL    = 4'h3;
    localparam logic [3:0]  TOC_A_FLAGS   = 4'h4;
    localparam logic [3:0]  TOC_A_IEN     = 4'h5;
    localparam logic [3:0]  TOC_A_FORCE   = 4'h6;
    localparam logic [3:0]  TOC_A_STAT    = 4'h7;
    // control register fields
    localparam int          TOC_CTL_WM_LO  = 0;
    localparam int          TOC_CTL_CS_LO  = 3;
    localparam int          TOC_CTL_ACTA_LO = 6;
    localparam int          TOC_CTL_ACTB_LO = 8;
    // flag register bits
    localparam int          TOC_F_CMPA    = 0;
    localparam int          TOC_F_CMPB    = 1;
    localparam int          TOC_F_OVF     = 2;
    localparam logic [15:0] TOC_CTRL_RST  = 16'h0000;
endpackage

// >>> toc_unit.sv
// timer output compare unit with counter, flags and pin override
`timescale 1ns/10ps
`default_nettype none
module toc_unit (
    input  wire logic        i_clk_sys,     // system clock, 50 MHz
    input  wire logic        i_arst_n,      // async reset, active low
    input  wire logic        i_tick,        // timer clock enable, same domain
    input  wire logic [3:0]  i_addr,        // register word address
    input  wire logic [15:0] i_wdata,       // write data
    input  wire logic        i_wr,          // write strobe
    input  wire logic        i_rd,          // read strobe
    input  wire logic [1:0]  i_port_val,    // general port output, a/b
    input  wire logic [1:0]  i_pin_dir,     // compare_pin_direction, a/b
    input  wire logic [2:0]  i_irq_ack,     // irq executed: cmpa,cmpb,ovf
    output logic      [15:0] o_rdata,       // read data, cycle after read
    output logic      [2:0]  o_irq,         // irq requests: cmpa,cmpb,ovf
    output logic      [1:0]  o_pin_out,     // pin output value, a/b
    output logic      [1:0]  o_pin_oe       // pin output enable, a/b
);
    import toc_pkg::*;

    logic [7:0]  timer_count_value_ff;
    logic [7:0]  cmp_active_ff [2];
    logic [7:0]  cmp_buf_ff [2];
    logic [15:0] ctrl_ff;
    logic [2:0]  flags_ff;
    logic [2:0]  ien_ff;
    logic [1:0]  compare_output_latch_ff;
    logic        block_ff;
    logic        dir_down_ff;
    logic [1:0]  match_d_ff;

    logic [2:0]  waveform_mode_select;
    logic [2:0]  clock_source_select;
    logic [1:0]  compare_output_action [2];
    logic        pwm_mode;
    logic        dual_slope;
    logic        top_is_a;
    logic [7:0]  top_val;
    logic        run;
    logic        at_top;
    logic        wr_count;
    logic [1:0]  match;
    logic [1:0]  force_compare_strobe;
    logic [7:0]  nxt_count;
    logic        nxt_dir_down;
    logic        update_pt;

    assign waveform_mode_select = ctrl_ff[TOC_CTL_WM_LO +: 3];
    assign clock_source_select  = ctrl_ff[TOC_CTL_CS_LO +: 3];
    assign compare_output_action[0] = ctrl_ff[TOC_CTL_ACTA_LO +: 2];
    assign compare_output_action[1] = ctrl_ff[TOC_CTL_ACTB_LO +: 2];
    assign pwm_mode   = (waveform_mode_select != TOC_WM_NORMAL)
                     && (waveform_mode_select != TOC_WM_CLRM);
    assign dual_slope = (waveform_mode_select == TOC_WM_PCPWM)
                     || (waveform_mode_select == TOC_WM_PCPWM_A);
    assign top_is_a   = (waveform_mode_select == TOC_WM_CLRM)
                     || (waveform_mode_select == TOC_WM_PCPWM_A)
                     || (waveform_mode_select == TOC_WM_FPWM_A);
    // top depends on mode and active compare a, never on action bits
    assign top_val  = top_is_a ? cmp_active_ff[0] : TOC_MAX;
    assign at_top   = (timer_count_value_ff == top_val);
    assign run      = i_tick
                   && (clock_source_select != TOC_CS_STOP);
    assign wr_count = i_wr && (i_addr == TOC_A_COUNT);
    assign force_compare_strobe = (i_wr && i_addr == TOC_A_FORCE)
                                ? i_wdata[1:0] : 2'h0;

    // comparator per channel, suppressed after a count write
    // a blocked match is dropped, never deferred to a later tick
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_cmp
            assign match[g] = run && !block_ff
                && (timer_count_value_ff == cmp_active_ff[g]);
        end
    endgenerate

    // next count and direction from mode and top
    always_comb begin
        nxt_count    = timer_count_value_ff + TOC_ONE;
        nxt_dir_down = dir_down_ff;
        if (dual_slope) begin
            if (!dir_down_ff && at_top) begin
                nxt_dir_down = 1'b1;
                nxt_count    = timer_count_value_ff - TOC_ONE;
            end else if (dir_down_ff
                         && timer_count_value_ff == TOC_BOTTOM) begin
                nxt_dir_down = 1'b0;
                nxt_count    = timer_count_value_ff + TOC_ONE;
            end else if (dir_down_ff) begin
                nxt_count    = timer_count_value_ff - TOC_ONE;
            end
        end else if (waveform_mode_select != TOC_WM_NORMAL && at_top) begin
            nxt_count = TOC_BOTTOM;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            timer_count_value_ff <= TOC_BOTTOM;
            dir_down_ff          <= 1'b0;
        end else if (wr_count) begin
            timer_count_value_ff <= i_wdata[7:0];
        end else if (run) begin
            timer_count_value_ff <= nxt_count;
            dir_down_ff          <= nxt_dir_down;
        end
    end

    // block lasts until the next timer tick, even if stopped
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            block_ff <= 1'b0;
        end else if (wr_count) begin
            block_ff <= 1'b1;
        end else if (i_tick) begin
            block_ff <= 1'b0;
        end
    end

    // buffer reload point: top for fast pwm, top while counting up for dual slope
    assign update_pt = run && (dual_slope ? at_top && !dir_down_ff
                                          : at_top);

    generate
        for (g = 0; g < 2; g++) begin : g_ocr
            logic write_cmp;
            assign write_cmp = i_wr
                && (i_addr == (g == 0 ? TOC_A_CMPA : TOC_A_CMPB));
            always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    cmp_buf_ff[g]    <= TOC_BOTTOM;
                    cmp_active_ff[g] <= TOC_BOTTOM;
                end else begin
                    if (write_cmp) begin
                        cmp_buf_ff[g] <= i_wdata[7:0];
                    end
                    if (!pwm_mode && write_cmp) begin
                        cmp_active_ff[g] <= i_wdata[7:0];
                    end else if (pwm_mode && update_pt) begin
                        cmp_active_ff[g] <= cmp_buf_ff[g];
                    end
                end
            end

            // latch: never touched by a mode change
            always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    compare_output_latch_ff[g] <= 1'b0;
                end else if (!pwm_mode && (match[g]
                             || force_compare_strobe[g])) begin
                    unique case (compare_output_action[g])
                        TOC_ACT_NONE: ;
                        TOC_ACT_TOG:
                            compare_output_latch_ff[g] <=
                                !compare_output_latch_ff[g];
                        TOC_ACT_CLR: compare_output_latch_ff[g] <= 1'b0;
                        TOC_ACT_SET: compare_output_latch_ff[g] <= 1'b1;
                    endcase
                end else if (pwm_mode && compare_output_action[g][1]) begin
                    // bit0 set means inverted polarity
                    if (match[g]) begin
                        compare_output_latch_ff[g] <=
                            (compare_output_action[g] == TOC_ACT_SET)
                            ^ (dual_slope && dir_down_ff);
                    end else if (run && !dual_slope && at_top) begin
                        compare_output_latch_ff[g] <=
                            (compare_output_action[g] == TOC_ACT_CLR);
                    end
                end else if (pwm_mode && match[g] && g == 0
                             && compare_output_action[g] == TOC_ACT_TOG
                             && waveform_mode_select[2]) begin
                    compare_output_latch_ff[g] <=
                        !compare_output_latch_ff[g];
                end
                // else value held across mode changes
            end

            // pin override, direction still from port logic
            always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    o_pin_out[g] <= 1'b0;
                    o_pin_oe[g]  <= 1'b0;
                end else begin
                    o_pin_out[g] <= (compare_output_action[g] != TOC_ACT_NONE)
                        ? compare_output_latch_ff[g]
                        : i_port_val[g];
                    o_pin_oe[g]  <= i_pin_dir[g];
                end
            end
        end
    endgenerate

    // flag set one tick after the match
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            match_d_ff <= 2'h0;
        end else if (i_tick) begin
            match_d_ff <= match;
        end
    end

    logic [2:0] flag_set;
    logic [2:0] flag_clr;
    assign flag_set[TOC_F_CMPA] = i_tick && match_d_ff[0];
    assign flag_set[TOC_F_CMPB] = i_tick && match_d_ff[1];
    // becomes zero from a count, not from a cpu write
    assign flag_set[TOC_F_OVF]  = run && !wr_count
        && (waveform_mode_select == TOC_WM_NORMAL
            || waveform_mode_select == TOC_WM_CLRM)
        && timer_count_value_ff == TOC_MAX;
    assign flag_clr = ((i_wr && i_addr == TOC_A_FLAGS) ? i_wdata[2:0]
                       : 3'h0) | i_irq_ack;

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            flags_ff <= 3'h0;
        end else begin
            flags_ff <= flag_set | (flags_ff & ~flag_clr);
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctrl_ff <= TOC_CTRL_RST;
            ien_ff  <= 3'h0;
        end else if (i_wr && i_addr == TOC_A_CTRL) begin
            ctrl_ff <= {6'h00, i_wdata[9:0]};
        end else if (i_wr && i_addr == TOC_A_IEN) begin
            ien_ff  <= i_wdata[2:0];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_irq <= 3'h0;
        end else begin
            o_irq <= flags_ff & ien_ff & ~i_irq_ack;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata <= 16'h0000;
        end else if (i_rd) begin
            unique case (i_addr)
                TOC_A_COUNT: o_rdata <= {8'h00, timer_count_value_ff};
                TOC_A_CMPA:  o_rdata <= {8'h00, pwm_mode ? cmp_buf_ff[0]
                                                 : cmp_active_ff[0]};
                TOC_A_CMPB:  o_rdata <= {8'h00, pwm_mode ? cmp_buf_ff[1]
                                                 : cmp_active_ff[1]};
                TOC_A_CTRL:  o_rdata <= ctrl_ff;
                TOC_A_FLAGS: o_rdata <= {13'h0000, flags_ff};
                TOC_A_IEN:   o_rdata <= {13'h0000, ien_ff};
                TOC_A_STAT:  o_rdata <= {13'h0000, dir_down_ff,
                                         compare_output_latch_ff};
                default:     o_rdata <= 16'h0000;
            endcase
        end else begin
            o_rdata <= 16'h0000;
        end
    end

    property p_flag_a;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_tick && match_d_ff[0]) |=> flags_ff[TOC_F_CMPA];
    endproperty
    a_flag_a: assert property (p_flag_a)
        else $error("flag a missed");
    property p_block;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        wr_count |=> !match[0] && !match[1];
    endproperty
    a_block: assert property (p_block)
        else $error("match not blocked");
    property p_wr_pri;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        wr_count |=> timer_count_value_ff == $past(i_wdata[7:0]);
    endproperty
    a_wr_pri: assert property (p_wr_pri)
        else $error("count write lost");
    property p_stop;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (clock_source_select == TOC_CS_STOP && !wr_count)
            |=> $stable(timer_count_value_ff);
    endproperty
    a_stop: assert property (p_stop)
        else $error("count moved stopped");
    property p_set_wins;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        flag_set[TOC_F_OVF] |=> flags_ff[TOC_F_OVF];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("ovf lost");
    property p_wrap;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (run && !wr_count && waveform_mode_select == TOC_WM_NORMAL
         && timer_count_value_ff == TOC_MAX)
            |=> timer_count_value_ff == TOC_BOTTOM;
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap");
    property p_none;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (compare_output_action[0] == TOC_ACT_NONE && !pwm_mode)
            |=> $stable(compare_output_latch_ff[0]);
    endproperty
    a_none: assert property (p_none) else $error("latch moved");
    property p_ovr;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        compare_output_action[1] != TOC_ACT_NONE
            |=> o_pin_out[1] == $past(compare_output_latch_ff[1]);
    endproperty
    a_ovr: assert property (p_ovr) else $error("no override");
    c_force: cover property (@(posedge i_clk_sys) force_compare_strobe[0]);
    c_ovf: cover property (@(posedge i_clk_sys) flag_set[TOC_F_OVF]);
    c_pwm: cover property (@(posedge i_clk_sys) pwm_mode && update_pt);
endmodule
`default_nettype wire
